// [exec_pkg.sv]
// Constants, types and opcode encodings for the skip, table-read and XOR executor
package exec_pkg;
  localparam int DATA_W = 8;
  localparam int DADDR_W = 9;
  localparam int PADDR_W = 16;
  localparam int PWORD_W = 16;
  localparam int BIT_SEL_W = 3;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] LAST_PAGE = 8'hFF;
  localparam logic [DATA_W-1:0] PTR_STEP = 8'h01;
  localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] SKIP_CYCLES = 2'h2;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_SKIP_MEM_NULL = 4'h1,
    OP_SKIP_NULL_MOVE = 4'h2,
    OP_SKIP_BIT_NULL = 4'h3,
    OP_TABLE_PAGED = 4'h4,
    OP_TABLE_LAST = 4'h5,
    OP_TABLE_PAGED_PREINC = 4'h6,
    OP_TABLE_LAST_PREINC = 4'h7,
    OP_XOR_REG = 4'h8,
    OP_XOR_MEM = 4'h9
  } op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_FETCH = 2'b10,
    ST_DUMMY = 2'b11
  } state_t;

  typedef struct packed {
    op_t op;
    logic [DADDR_W-1:0] addr;
    logic [BIT_SEL_W-1:0] bit_sel;
  } cmd_t;

  typedef struct packed {
    logic we;
    logic [DADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dmem_wr_t;
endpackage

// [skip_table_xor_exec.sv]
// Executor for skip-if-zero, table-read and XOR instructions
`timescale 1ns/1ps
module skip_table_xor_exec
  import exec_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic cmd_valid_in,
  input wire cmd_t cmd_in,
  input wire logic [DATA_W-1:0] dmem_rdata_in,
  input wire logic [PWORD_W-1:0] pmem_rdata_in,
  input wire logic [DATA_W-1:0] tbl_ptr_low_wdata_in,
  input wire logic [DATA_W-1:0] tbl_ptr_high_wdata_in,
  input wire logic tbl_ptr_low_we_in,
  input wire logic tbl_ptr_high_we_in,
  output logic busy_out,
  output logic done_out,
  output logic skip_out,
  output logic dummy_out,
  output logic [DADDR_W-1:0] dmem_raddr_out,
  output dmem_wr_t dmem_wr_out,
  output logic [PADDR_W-1:0] pmem_addr_out,
  output logic [DATA_W-1:0] working_register_out,
  output logic [DATA_W-1:0] table_high_latch_out,
  output logic [DATA_W-1:0] table_pointer_low_out,
  output logic [DATA_W-1:0] table_pointer_high_out,
  output logic zero_flag_out
);
  state_t state_q, state_d;
  cmd_t cmd_q, cmd_d;
  logic busy_q, busy_d, done_q, done_d, skip_q, skip_d, dummy_q, dummy_d;
  logic [DADDR_W-1:0] raddr_q, raddr_d;
  dmem_wr_t wr_q, wr_d;
  logic [PADDR_W-1:0] paddr_q, paddr_d;
  logic [DATA_W-1:0] wreg_q, wreg_d, table_high_latch_q, table_high_latch_d, table_pointer_low_q, table_pointer_low_d, table_pointer_high_q, table_pointer_high_d;
  logic zf_q, zf_d;
  logic is_zero;
  logic [DATA_W-1:0] xor_val;
  logic [DATA_W-1:0] ptr_next;

  zero_detect u_zero (
    .value_in(dmem_rdata_in),
    .bit_sel_in(cmd_q.bit_sel),
    .bit_mode_in(cmd_q.op == OP_SKIP_BIT_NULL),
    .zero_out(is_zero)
  );

  assign xor_val = wreg_q ^ dmem_rdata_in;
  assign ptr_next = table_pointer_low_q + PTR_STEP;

  always_comb begin
    state_d = state_q;
    cmd_d = cmd_q;
    busy_d = busy_q;
    done_d = 1'b0;
    skip_d = 1'b0;
    dummy_d = 1'b0;
    raddr_d = raddr_q;
    wr_d = '0;
    paddr_d = paddr_q;
    wreg_d = wreg_q;
    table_high_latch_d = table_high_latch_q;
    table_pointer_low_d = tbl_ptr_low_we_in ? tbl_ptr_low_wdata_in : table_pointer_low_q;
    table_pointer_high_d = tbl_ptr_high_we_in ? tbl_ptr_high_wdata_in : table_pointer_high_q;
    zf_d = zf_q;
    case (state_q)
      ST_IDLE: begin
        if (cmd_valid_in && cmd_in.op != OP_NONE) begin
          cmd_d = cmd_in;
          busy_d = 1'b1;
          raddr_d = cmd_in.addr;
          case (cmd_in.op)
            OP_TABLE_PAGED: begin
              paddr_d = {table_pointer_high_d, table_pointer_low_d};
              state_d = ST_FETCH;
            end
            OP_TABLE_LAST: begin
              paddr_d = {LAST_PAGE, table_pointer_low_d};
              state_d = ST_FETCH;
            end
            OP_TABLE_PAGED_PREINC: begin
              table_pointer_low_d = table_pointer_low_d + PTR_STEP;
              paddr_d = {table_pointer_high_d, table_pointer_low_d};
              state_d = ST_FETCH;
            end
            OP_TABLE_LAST_PREINC: begin
              table_pointer_low_d = table_pointer_low_d + PTR_STEP;
              paddr_d = {LAST_PAGE, table_pointer_low_d};
              state_d = ST_FETCH;
            end
            default: state_d = ST_READ;
          endcase
        end
      end
      ST_READ: begin
        state_d = ST_IDLE;
        busy_d = 1'b0;
        done_d = 1'b1;
        case (cmd_q.op)
          OP_SKIP_MEM_NULL: begin
            wr_d = '{we: 1'b1, addr: cmd_q.addr, wdata: dmem_rdata_in};
          end
          OP_SKIP_NULL_MOVE: begin
            wreg_d = dmem_rdata_in;
          end
          OP_XOR_REG: begin
            wreg_d = xor_val;
            zf_d = (xor_val == ZERO_BYTE);
          end
          OP_XOR_MEM: begin
            wr_d = '{we: 1'b1, addr: cmd_q.addr, wdata: xor_val};
            zf_d = (xor_val == ZERO_BYTE);
          end
          default: ;
        endcase
        // Skip on zero byte or zero bit; flags untouched
        if ((cmd_q.op == OP_SKIP_MEM_NULL || cmd_q.op == OP_SKIP_NULL_MOVE ||
             cmd_q.op == OP_SKIP_BIT_NULL) && is_zero) begin
          skip_d = 1'b1;
          busy_d = 1'b1;
          done_d = 1'b0;
          state_d = ST_DUMMY;
        end
      end
      ST_FETCH: begin
        wr_d = '{we: 1'b1, addr: cmd_q.addr, wdata: pmem_rdata_in[DATA_W-1:0]};
        table_high_latch_d = pmem_rdata_in[PWORD_W-1:DATA_W];
        state_d = ST_IDLE;
        busy_d = 1'b0;
        done_d = 1'b1;
      end
      ST_DUMMY: begin
        dummy_d = 1'b1;
        busy_d = 1'b0;
        done_d = 1'b1;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
        busy_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state_q <= ST_IDLE;
      cmd_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      skip_q <= 1'b0;
      dummy_q <= 1'b0;
      raddr_q <= '0;
      wr_q <= '0;
      paddr_q <= '0;
      wreg_q <= RESET_BYTE;
      table_high_latch_q <= RESET_BYTE;
      table_pointer_low_q <= RESET_BYTE;
      table_pointer_high_q <= RESET_BYTE;
      zf_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      busy_q <= busy_d;
      done_q <= done_d;
      skip_q <= skip_d;
      dummy_q <= dummy_d;
      raddr_q <= raddr_d;
      wr_q <= wr_d;
      paddr_q <= paddr_d;
      wreg_q <= wreg_d;
      table_high_latch_q <= table_high_latch_d;
      table_pointer_low_q <= table_pointer_low_d;
      table_pointer_high_q <= table_pointer_high_d;
      zf_q <= zf_d;
    end
  end

  assign busy_out = busy_q;
  assign done_out = done_q;
  assign skip_out = skip_q;
  assign dummy_out = dummy_q;
  assign dmem_raddr_out = raddr_q;
  assign dmem_wr_out = wr_q;
  assign pmem_addr_out = paddr_q;
  assign working_register_out = wreg_q;
  assign table_high_latch_out = table_high_latch_q;
  assign table_pointer_low_out = table_pointer_low_q;
  assign table_pointer_high_out = table_pointer_high_q;
  assign zero_flag_out = zf_q;

  // Assertions
  // Skip pulse while still busy, then dummy and done as busy drops
  sequence s_skip_taken;
    (skip_q && busy_q) ##1 (dummy_q && done_q && !busy_q);
  endsequence

  a_skip_dummy_follows: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    skip_q |-> ##1 dummy_q)
    else $error("taken skip not followed by dummy cycle");

  a_skip_three_cycles: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (state_q == ST_IDLE && cmd_valid_in && cmd_in.op == OP_SKIP_MEM_NULL) ##1
    (state_q == ST_READ && is_zero) |-> ##1 s_skip_taken)
    else $error("skip did not span three cycles");

  a_byte_skip_rewrite: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (state_q == ST_READ && cmd_q.op == OP_SKIP_MEM_NULL) |=>
    (dmem_wr_out.we && dmem_wr_out.wdata == $past(dmem_rdata_in)))
    else $error("byte skip did not write value back");

  a_byte_skip_zero: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (state_q == ST_READ && cmd_q.op == OP_SKIP_MEM_NULL) |=>
    (skip_q == ($past(dmem_rdata_in) == ZERO_BYTE)))
    else $error("byte skip decision wrong");

  a_flags_kept_skip: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (state_q != ST_IDLE && cmd_q.op != OP_XOR_REG && cmd_q.op != OP_XOR_MEM) |=>
    $stable(zf_q))
    else $error("flag changed on skip or table read");

  a_move_skip_copy: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (state_q == ST_READ && cmd_q.op == OP_SKIP_NULL_MOVE) |=>
    (wreg_q == $past(dmem_rdata_in) && skip_q == (wreg_q == ZERO_BYTE)))
    else $error("skip with move wrong");

  a_bit_skip_test: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (state_q == ST_READ && cmd_q.op == OP_SKIP_BIT_NULL) |=>
    (skip_q == !$past(dmem_rdata_in[cmd_q.bit_sel])))
    else $error("bit skip decision wrong");

  a_paged_read_split: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (state_q == ST_FETCH) |=> (dmem_wr_out.wdata == $past(pmem_rdata_in[7:0]) &&
    table_high_latch_q == $past(pmem_rdata_in[15:8])))
    else $error("table read bytes misplaced");

  a_last_page_addr: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (state_q == ST_FETCH && (cmd_q.op == OP_TABLE_LAST || cmd_q.op == OP_TABLE_LAST_PREINC))
    |-> pmem_addr_out[15:8] == LAST_PAGE)
    else $error("last page address wrong");

  a_preinc_paged: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (state_q == ST_IDLE && cmd_valid_in && cmd_in.op == OP_TABLE_PAGED_PREINC &&
     !tbl_ptr_low_we_in) |=> (table_pointer_low_q == $past(ptr_next) && pmem_addr_out[7:0] == table_pointer_low_q))
    else $error("preincrement paged read wrong");

  a_preinc_last: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (state_q == ST_IDLE && cmd_valid_in && cmd_in.op == OP_TABLE_LAST_PREINC &&
     !tbl_ptr_low_we_in) |=> (pmem_addr_out == {LAST_PAGE, $past(ptr_next)}))
    else $error("preincrement last page read wrong");

  a_xor_register: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (state_q == ST_READ && cmd_q.op == OP_XOR_REG) |=>
    (wreg_q == $past(xor_val) && zf_q == (wreg_q == ZERO_BYTE) && !dmem_wr_out.we))
    else $error("xor into register wrong");

  a_xor_memory: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (state_q == ST_READ && cmd_q.op == OP_XOR_MEM) |=>
    (dmem_wr_out.we && dmem_wr_out.wdata == $past(xor_val) && $stable(wreg_q)))
    else $error("xor into memory wrong");
endmodule

// [tb_top.sv]
// Self-checking testbench for the skip, table-read and XOR executor
`timescale 1ns/1ps
module tb_top;
  import exec_pkg::*;
  typedef struct packed {
    logic skip;
    logic wchk;
    logic we;
    logic [8:0] wa;
    logic [7:0] wd;
    logic [7:0] wreg;
    logic zf;
    logic [7:0] table_high_latch;
    logic [7:0] lo;
    logic [7:0] hi;
  } exp_t;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic cmd_valid_in = 1'b0;
  cmd_t cmd_in = '0;
  logic [7:0] dmem_rdata_in, lo_wd = 8'h00, hi_wd = 8'h00;
  logic [15:0] pmem_rdata_in;
  logic lo_we = 1'b0, hi_we = 1'b0;
  logic busy_out, done_out, skip_out, dummy_out, zero_flag_out;
  logic [8:0] dmem_raddr_out;
  dmem_wr_t dmem_wr_out;
  logic [15:0] pmem_addr_out;
  logic [7:0] wreg_o, table_high_latch_o, plo_o, phi_o;
  logic [7:0] mem [0:511];
  logic [7:0] exp_mem [0:511];
  logic [7:0] wreg_m = 8'h00, table_high_latch_m = 8'h00, lo_m = 8'h00, hi_m = 8'h00;
  logic zf_m = 1'b0, sk = 1'b0, dm = 1'b0, wr = 1'b0;
  logic [8:0] wa;
  logic [7:0] wd;
  logic [31:0] seed = 32'hfa1d_eedb, v;
  int blen = 0, num_errors = 0, comparisons = 0, cycles = 0;
  exp_t q[$];
  exp_t e;

  skip_table_xor_exec u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .cmd_valid_in(cmd_valid_in),
    .cmd_in(cmd_in), .dmem_rdata_in(dmem_rdata_in), .pmem_rdata_in(pmem_rdata_in),
    .tbl_ptr_low_wdata_in(lo_wd), .tbl_ptr_high_wdata_in(hi_wd), .tbl_ptr_low_we_in(lo_we),
    .tbl_ptr_high_we_in(hi_we), .busy_out(busy_out), .done_out(done_out), .skip_out(skip_out),
    .dummy_out(dummy_out), .dmem_raddr_out(dmem_raddr_out), .dmem_wr_out(dmem_wr_out),
    .pmem_addr_out(pmem_addr_out), .working_register_out(wreg_o),
    .table_high_latch_out(table_high_latch_o), .table_pointer_low_out(plo_o),
    .table_pointer_high_out(phi_o), .zero_flag_out(zero_flag_out));

  always #12.5 clk_in = ~clk_in;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Program word depends on both address bytes so a wrong page shows up
  function automatic logic [15:0] pw(input logic [15:0] a);
    return {a[7:0] ^ 8'h3c, a[15:8] ^ 8'hc5};
  endfunction

  assign pmem_rdata_in = pw(pmem_addr_out);
  assign dmem_rdata_in = mem[dmem_raddr_out];
  always @(posedge clk_in) begin
    if (dmem_wr_out.we) mem[dmem_wr_out.addr] <= dmem_wr_out.wdata;
  end

  task automatic final_report();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string n, input logic [15:0] s, input logic [15:0] x);
    comparisons++;
    if (s !== x) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask

  task automatic set_ptr(input logic [7:0] lo, input logic [7:0] hi);
    @(posedge clk_in);
    lo_we <= 1'b1;
    hi_we <= 1'b1;
    lo_wd <= lo;
    hi_wd <= hi;
    @(posedge clk_in);
    lo_we <= 1'b0;
    hi_we <= 1'b0;
    lo_m = lo;
    hi_m = hi;
  endtask

  // Command stays valid while busy, so the next one waits for the idle edge
  task automatic issue(input op_t op, input logic [8:0] a, input logic [2:0] b);
    exp_t x;
    logic [7:0] d;
    logic [15:0] w;
    d = exp_mem[a];
    if (op == OP_TABLE_PAGED_PREINC || op == OP_TABLE_LAST_PREINC) lo_m = lo_m + 8'h01;
    w = (op == OP_TABLE_LAST || op == OP_TABLE_LAST_PREINC) ? pw({8'hff, lo_m}) : pw({hi_m, lo_m});
    x = '0;
    x.wchk = 1'b1;
    x.wa = a;
    case (op)
      OP_SKIP_MEM_NULL: begin
        x.skip = (d == 8'h00);
        x.we = 1'b1;
        x.wd = d;
      end
      OP_SKIP_NULL_MOVE: begin
        x.skip = (d == 8'h00);
        wreg_m = d;
      end
      OP_SKIP_BIT_NULL: begin
        x.skip = !d[b];
      end
      OP_XOR_REG: begin
        wreg_m = wreg_m ^ d;
        zf_m = (wreg_m == 8'h00);
      end
      OP_XOR_MEM: begin
        x.we = 1'b1;
        x.wd = wreg_m ^ d;
        zf_m = (x.wd == 8'h00);
      end
      default: begin
        x.we = 1'b1;
        x.wd = w[7:0];
        table_high_latch_m = w[15:8];
      end
    endcase
    if (x.we) exp_mem[a] = x.wd;
    x.wreg = wreg_m;
    x.zf = zf_m;
    x.table_high_latch = table_high_latch_m;
    x.lo = lo_m;
    x.hi = hi_m;
    @(posedge clk_in);
    cmd_in <= cmd_t'{op, a, b};
    cmd_valid_in <= 1'b1;
    do @(negedge clk_in); while (busy_out !== 1'b0);
    @(posedge clk_in);
    q.push_back(x);
  endtask

  // Idle opcode stays valid for a while and must never raise done
  task automatic stop();
    @(posedge clk_in);
    cmd_in <= '0;
    repeat (5) @(posedge clk_in);
    cmd_valid_in <= 1'b0;
  endtask

  always @(negedge clk_in) begin
    if (rst_b_in) begin
      if (busy_out === 1'b1) blen++;
      if (skip_out === 1'b1) sk = 1'b1;
      if (dummy_out === 1'b1) dm = 1'b1;
      if (dmem_wr_out.we === 1'b1) begin
        wr = 1'b1;
        wa = dmem_wr_out.addr;
        wd = dmem_wr_out.wdata;
      end
      if (done_out === 1'b1) begin
        if (q.size() == 0) begin
          check("queue", 16'h0001, 16'h0000);
        end else begin
          e = q.pop_front();
          check("skip", sk, e.skip);
          check("dummy", dm, e.skip);
          check("busy_cycles", 16'(blen), e.skip ? 16'h0002 : 16'h0001);
          check("wreg", wreg_o, e.wreg);
          check("zflag", zero_flag_out, e.zf);
          check("table_high_latch", table_high_latch_o, e.table_high_latch);
          check("ptr_low", plo_o, e.lo);
          check("ptr_high", phi_o, e.hi);
          if (e.wchk) check("we", wr, e.we);
          if (e.wchk && e.we) check("waddr", wa, e.wa);
          if (e.wchk && e.we) check("wdata", wd, e.wd);
        end
        sk = 1'b0;
        dm = 1'b0;
        wr = 1'b0;
        blen = 0;
      end
    end
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      final_report();
    end
  end

  initial begin
    for (int i = 0; i < 512; i++) begin
      v = rnd();
      mem[i] = (i % 4 == 0 || v[1:0] == 2'h0) ? 8'h00 : v[7:0];
      exp_mem[i] = mem[i];
    end
    repeat (10) @(posedge clk_in);
    rst_b_in <= 1'b1;
    set_ptr(8'hff, 8'h12);
    for (int k = 1; k < 10; k++) issue(op_t'(k), 9'(k % 4), 3'(k));
    stop();
    $display("Test directed done");
    for (int n = 0; n < 8; n++) begin
      v = rnd();
      set_ptr(v[7:0] | 8'hf8, v[15:8]);
      repeat (12) begin
        v = rnd();
        issue(op_t'(v[3:0] % 9 + 1), {6'h00, v[6:4]}, v[10:8]);
      end
      stop();
    end
    $display("Test random done");
    check("pending", 16'(q.size()), 16'h0000);
    final_report();
  end
endmodule

// [zero_detect.sv]
// Zero test of a byte or of one selected bit
`timescale 1ns/1ps
module zero_detect
  import exec_pkg::*;
(
  input wire logic [DATA_W-1:0] value_in,
  input wire logic [BIT_SEL_W-1:0] bit_sel_in,
  input wire logic bit_mode_in,
  output logic zero_out
);
  always_comb begin
    if (bit_mode_in) begin
      zero_out = ~value_in[bit_sel_in];
    end else begin
      zero_out = (value_in == ZERO_BYTE);
    end
  end
endmodule
